/* File: lcdcl_column_mux.sv */
// Per-column drive level select from latched bit and frame polarity.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
`include "lcdcl_defs.svh"
module lcdcl_column_mux (
    input wire logic [`LCDCL_COLS-1:0] bits_in, // Latched line data
    input wire logic frame_polarity_in, // Frame polarity
    output logic [`LCDCL_COLS*`LCDCL_LEVEL_W-1:0] levels_out // Level code per column
);
    // Four-way level pick for each column
    always_comb begin
        levels_out = '0;
        for (int c = 0; c < `LCDCL_COLS; c++) begin
            case ({bits_in[c], frame_polarity_in})
                2'h3: levels_out[c*`LCDCL_LEVEL_W +: `LCDCL_LEVEL_W] = lcdcl_pkg::LCDCL_LEVEL_TOP; // R10
                2'h2: levels_out[c*`LCDCL_LEVEL_W +: `LCDCL_LEVEL_W] = lcdcl_pkg::LCDCL_LEVEL_BOTTOM; // R10
                2'h1: levels_out[c*`LCDCL_LEVEL_W +: `LCDCL_LEVEL_W] = lcdcl_pkg::LCDCL_LEVEL_MID_HIGH; // R10
                default: levels_out[c*`LCDCL_LEVEL_W +: `LCDCL_LEVEL_W] = lcdcl_pkg::LCDCL_LEVEL_MID_LOW; // R10
            endcase
        end
    end
endmodule

/* File: lcdcl_ctrl_model.sv */
// Behavioural display controller that feeds one column driver loader.
// Assumes the same reference clock as the loader; tasks are called from the bench.
`timescale 1ns/100ps
`include "lcdcl_defs.svh"
module lcdcl_ctrl_model (
    input wire logic ref_clk_in, // Reference clock
    output logic shift_clock_out, // Data shift clock
    output logic [`LCDCL_NIB_W-1:0] nibble_out, // Display data nibble
    output logic latch_pulse_out // Line latch pulse
);
    // Idle levels: shift clock and latch rest low between frames
    initial begin
        shift_clock_out = 1'b0;
        latch_pulse_out = 1'b0;
        nibble_out = 4'h0;
    end

    // One nibble: 18 ref cycles from fall to fall, just inside the top shift rate
    task automatic send_nibble(input logic [`LCDCL_NIB_W-1:0] nib);
        @(posedge ref_clk_in);
        nibble_out <= nib;
        shift_clock_out <= 1'b1;
        repeat (8) @(posedge ref_clk_in);
        shift_clock_out <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        // Data no longer held, so show its inverse instead of a stale value
        nibble_out <= ~nib;
        repeat (6) @(posedge ref_clk_in);
    endtask

    // Latch pulse well after the last shift fall, then time for the copy
    task automatic pulse_latch();
        repeat (8) @(posedge ref_clk_in);
        latch_pulse_out <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        latch_pulse_out <= 1'b0;
        repeat (10) @(posedge ref_clk_in);
    endtask
endmodule

/* File: lcdcl_defs.svh */
// Constants of the column driver loader: geometry, depths and pin timing.
// Assumes nothing; included by the package and by every design file but the FIFO.
`ifndef LCDCL_DEFS_SVH
`define LCDCL_DEFS_SVH

`define LCDCL_COLS 80
`define LCDCL_NIBBLES 20
`define LCDCL_NIB_W 4
`define LCDCL_SLOT_W 5
`define LCDCL_LAST_SLOT 5'h13
`define LCDCL_LAST_COL 7'h4F
`define LCDCL_FIFO_DEPTH 4
`define LCDCL_LEVEL_W 2
`define LCDCL_REF_CLK_MHZ 100
`define LCDCL_SCLK_MAX_MHZ 6
`define LCDCL_SCLK_MIN_CYCLES ((`LCDCL_REF_CLK_MHZ + `LCDCL_SCLK_MAX_MHZ - 1) / `LCDCL_SCLK_MAX_MHZ)

`endif

/* File: lcdcl_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module lcdcl_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk_in, // Clock
    input wire logic rst_n_in, // Synchronous reset, low
    input wire logic in_valid_in, // Write request
    output logic in_ready_out, // Room for a word
    input wire logic [WIDTH-1:0] in_data_in, // Write data
    output logic out_valid_out, // Word available
    input wire logic out_ready_in, // Reader takes word
    output logic [WIDTH-1:0] out_data_out // Head word
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0] fill;
    } lcdcl_fifo_state_t;

    lcdcl_fifo_state_t st;
    lcdcl_fifo_state_t next_st;
    logic push;
    logic pop;

    // Handshakes straight from the fill level
    assign in_ready_out = (st.fill != DEPTH[PW:0]);
    assign out_valid_out = (st.fill != '0);
    assign out_data_out = st.mem[st.rd_ptr];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    // Pointer wrap assumes a power-of-two depth
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr_ptr] = in_data_in;
            next_st.wr_ptr = st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = st.rd_ptr + 1'b1;
        end
        next_st.fill = st.fill + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    AST_FIFO_NO_OVERRUN: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        st.fill <= DEPTH) else $error("fifo fill above depth");
endmodule

/* File: lcdcl_loader.sv */
// Column driver loader: nibble capture, two-stage line register, chain enable.
// Assumes all pins synchronous to ref_clk_in; shift clock well below ref clock.
// Function
// (R1) Data is captured on each falling edge of the shift clock while the controller holds it valid there.
// (R2) Each nibble is written into the first-stage register at a place set by the direction select.
// (R3) The driver only works while its selected chain enable input is high, otherwise clock and data are held low.
// (R4) After 20 nibbles (80 bits) the selected chain enable output goes high.
// (R5) The latch pulse clears the chain enable output.
// (R6) The first driver of a cascade has its enable input tied high by the system.
// (R7) Twenty channel shift strobes, one per 4-bit channel, are derived from the shift clock.
// (R8) On the latch pulse falling edge the first stage is copied whole into the second stage.
// (R9) The 80-bit second stage holds the line data and feeds each column for the whole line.
// (R10) Each column picks one of four levels from its latched bit and the frame polarity.
// (R11) Direction low maps the first bit to column 79, uses line a as output and line b as input.
// (R12) Direction high maps the first bit to column 0, uses line a as input and line b as output.
// (R13) Chain enables are active high and the input line takes the previous driver's output.
// (R14) The controller keeps the shift clock at or below 6 MHz.
// (R15) Once full, further shift clocks are ignored until the next latch pulse.
`timescale 1ns/100ps
`include "lcdcl_defs.svh"
module lcdcl_loader (
    input wire logic ref_clk_in, // 100 MHz clock
    input wire logic rst_n_in, // Synchronous reset, low
    input wire logic shift_clock_in, // Data shift clock
    input wire logic [`LCDCL_NIB_W-1:0] nibble_inputs_in, // Display data nibble
    input wire logic latch_pulse_in, // Line latch pulse
    input wire logic direction_select_in, // Shift direction
    input wire logic frame_polarity_in, // Frame polarity
    input wire logic chain_enable_a_in, // Chain line a, pin level
    output logic chain_enable_a_out, // Chain line a, driven value
    output logic chain_enable_a_oe_out, // Chain line a, drive enable
    input wire logic chain_enable_b_in, // Chain line b, pin level
    output logic chain_enable_b_out, // Chain line b, driven value
    output logic chain_enable_b_oe_out, // Chain line b, drive enable
    output logic load_ready_out, // Capture buffer has room
    output logic [`LCDCL_COLS*`LCDCL_LEVEL_W-1:0] column_outputs_out // Level code per column
);
    localparam int FIFO_W = `LCDCL_SLOT_W + `LCDCL_NIB_W;

    lcdcl_pkg::lcdcl_state_t st;
    lcdcl_pkg::lcdcl_state_t next_st;
    logic enabled;
    logic [`LCDCL_NIB_W-1:0] int_data;
    logic sclk_fall;
    logic latch_fall;
    logic push_valid;
    logic push_ready;
    logic push_fire;
    logic pop_valid;
    logic pop_ready;
    logic pop_fire;
    logic [FIFO_W-1:0] pop_word;
    logic [`LCDCL_SLOT_W-1:0] pop_slot;
    logic [`LCDCL_NIB_W-1:0] pop_nib;
    logic [`LCDCL_NIBBLES-1:0] chan_strobe;
    logic copy_now;
    logic enable_out;
    logic [`LCDCL_COLS*`LCDCL_LEVEL_W-1:0] mux_levels;

    // Column index for bit j of nibble slot k in the chosen direction
    function automatic logic [6:0] col_of(input logic [`LCDCL_SLOT_W-1:0] slot, input logic [1:0] bit_i,
                                          input logic dir);
        logic [6:0] idx;
        idx = {slot, bit_i};
        return dir ? idx : (`LCDCL_LAST_COL - idx);
    endfunction

    // One strobe per channel from the slot being written
    function automatic logic [`LCDCL_NIBBLES-1:0] chan_decode(input logic fire,
                                                             input logic [`LCDCL_SLOT_W-1:0] slot);
        logic [`LCDCL_NIBBLES-1:0] v;
        v = '0;
        for (int k = 0; k < `LCDCL_NIBBLES; k++) begin
            v[k] = fire && (slot == k[`LCDCL_SLOT_W-1:0]);
        end
        return v;
    endfunction

    // Input enable picked by direction; the other line is our output
    assign enabled = direction_select_in ? chain_enable_a_in : chain_enable_b_in; // R13
    assign int_data = enabled ? nibble_inputs_in : '0; // R3
    assign sclk_fall = st.sclk_prev & ~shift_clock_in; // R1
    assign latch_fall = st.latch_prev & ~latch_pulse_in; // R8

    // Capture only while enabled and still loading; full ignores clocks
    assign push_valid = sclk_fall & enabled & (st.phase == lcdcl_pkg::LCDCL_PH_LOAD); // R3 R15
    assign push_fire = push_valid & push_ready;
    assign load_ready_out = push_ready;

    // Drain stalls in the latch edge cycle so the copy sees a settled stage
    assign pop_ready = ~latch_fall;
    assign pop_fire = pop_valid & pop_ready;
    assign pop_slot = pop_word[FIFO_W-1 -: `LCDCL_SLOT_W];
    assign pop_nib = pop_word[`LCDCL_NIB_W-1:0];
    assign chan_strobe = chan_decode(pop_fire, pop_slot); // R7

    // Copy waits until every captured nibble has landed
    assign copy_now = (st.phase == lcdcl_pkg::LCDCL_PH_COPY) & ~pop_valid;
    assign enable_out = (st.phase == lcdcl_pkg::LCDCL_PH_FULL); // R4

    // Chain pins: line a drives when direction is low, line b when high
    assign chain_enable_a_out = enable_out & ~direction_select_in; // R11
    assign chain_enable_a_oe_out = ~direction_select_in; // R11
    assign chain_enable_b_out = enable_out & direction_select_in; // R12
    assign chain_enable_b_oe_out = direction_select_in; // R12
    assign column_outputs_out = st.columns;

    lcdcl_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(`LCDCL_FIFO_DEPTH)
    ) u_capture_fifo (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(push_valid),
        .in_ready_out(push_ready),
        .in_data_in({st.count, int_data}),
        .out_valid_out(pop_valid),
        .out_ready_in(pop_ready),
        .out_data_out(pop_word)
    );

    lcdcl_column_mux u_column_mux (
        .bits_in(st.stage2),
        .frame_polarity_in(frame_polarity_in),
        .levels_out(mux_levels)
    );

    // Next state of the loader
    always_comb begin
        next_st = st;
        next_st.sclk_prev = shift_clock_in;
        next_st.latch_prev = latch_pulse_in;
        next_st.columns = mux_levels; // R9 R10
        // Channel writes, bit 0 of a nibble is its first bit
        for (int k = 0; k < `LCDCL_NIBBLES; k++) begin
            if (chan_strobe[k]) begin
                for (int j = 0; j < `LCDCL_NIB_W; j++) begin
                    next_st.stage1[col_of(k[`LCDCL_SLOT_W-1:0], j[1:0], direction_select_in)] = pop_nib[j]; // R2
                end
            end
        end
        if (push_fire) begin
            next_st.count = st.count + 1'b1; // R4
        end
        case (st.phase)
            lcdcl_pkg::LCDCL_PH_LOAD: begin
                if (push_fire && st.count == `LCDCL_LAST_SLOT) begin
                    next_st.phase = lcdcl_pkg::LCDCL_PH_FULL; // R4
                end
            end
            lcdcl_pkg::LCDCL_PH_FULL: begin
                next_st.phase = lcdcl_pkg::LCDCL_PH_FULL; // R15
            end
            lcdcl_pkg::LCDCL_PH_COPY: begin
                if (copy_now) begin
                    next_st.stage2 = st.stage1; // R8
                    next_st.count = '0;
                    next_st.phase = lcdcl_pkg::LCDCL_PH_LOAD;
                end
            end
            default: begin
                next_st.phase = lcdcl_pkg::LCDCL_PH_LOAD;
            end
        endcase
        // Latch edge wins from any phase and drops the enable output
        if (latch_fall) begin
            next_st.phase = lcdcl_pkg::LCDCL_PH_COPY; // R5
        end
    end

    // State register; latch pulse is the only line-level clear besides reset
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            st <= '{phase: lcdcl_pkg::LCDCL_PH_LOAD, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_CAPTURE_ON_FALL: assert property ( // R1
        push_valid |-> ($past(shift_clock_in) && !shift_clock_in))
        else $error("capture without shift clock fall");

    AST_DISABLED_IDLE: assert property ( // R3
        !enabled |-> (!push_valid && int_data == '0))
        else $error("disabled driver captured or drove data");

    AST_ENABLE_AFTER_TWENTY: assert property ( // R4
        (push_fire && st.count == `LCDCL_LAST_SLOT && !latch_fall) |=> enable_out)
        else $error("enable output not raised after twentieth nibble");

    AST_LATCH_CLEARS_ENABLE: assert property ( // R5
        latch_fall |=> (!enable_out && !chain_enable_a_out && !chain_enable_b_out))
        else $error("latch pulse did not clear enable output");

    AST_STROBE_MATCHES_SLOT: assert property ( // R7
        pop_fire |-> (chan_strobe[pop_slot] && $onehot(chan_strobe)))
        else $error("channel strobe does not match slot");

    AST_COPY_WHOLE: assert property ( // R8
        copy_now |=> (st.stage2 == $past(st.stage1) && st.count == '0))
        else $error("second stage not loaded from first stage");

    AST_STAGE2_HOLDS: assert property ( // R9
        !copy_now |=> $stable(st.stage2))
        else $error("second stage changed outside a copy");

    // Skips the first edge after reset, where the column register still holds its reset value
    AST_LEVEL_COL0: assert property ( // R10
        $past(rst_n_in) |-> (column_outputs_out[1:0] == ($past(st.stage2[0])
            ? ($past(frame_polarity_in) ? 2'h0 : 2'h3) : ($past(frame_polarity_in) ? 2'h1 : 2'h2))))
        else $error("column 0 level wrong");

    AST_DIR_LOW_MAP: assert property ( // R11
        (pop_fire && !direction_select_in && pop_slot == '0) |=> st.stage1[`LCDCL_LAST_COL] == $past(pop_nib[0]))
        else $error("first bit not at column 79 in low direction");

    AST_DIR_HIGH_MAP: assert property ( // R12
        (pop_fire && direction_select_in && pop_slot == '0) |=> st.stage1[0] == $past(pop_nib[0]))
        else $error("first bit not at column 0 in high direction");

    AST_PIN_ROLES: assert property ( // R13
        (chain_enable_a_oe_out != chain_enable_b_oe_out) && (enabled == (direction_select_in ? chain_enable_a_in
            : chain_enable_b_in)))
        else $error("chain pin roles inconsistent");

    AST_FULL_IGNORES: assert property ( // R15
        (st.phase == lcdcl_pkg::LCDCL_PH_FULL && sclk_fall) |=> $stable(st.count))
        else $error("full driver took another nibble");

    // Count never runs past a full line, so extra shift clocks are truly dropped
    AST_COUNT_LIMIT: assert property ( // R15
        st.count <= `LCDCL_NIBBLES)
        else $error("nibble count ran past a full line");

    COV_FILLED: cover property (push_fire && st.count == `LCDCL_LAST_SLOT);
    COV_LINE_COPIED: cover property (copy_now);
    COV_BUFFER_FULL: cover property (!push_ready);
    COV_HIGH_DIR_FULL: cover property (direction_select_in && enable_out);
endmodule

/* File: lcdcl_pkg.sv */
// Types shared by the column driver loader files.
// Assumes lcdcl_defs.svh for widths.
`include "lcdcl_defs.svh"
package lcdcl_pkg;

    // Drive level chosen for one column
    typedef enum logic [`LCDCL_LEVEL_W-1:0] {
        LCDCL_LEVEL_TOP = 2'h0,
        LCDCL_LEVEL_MID_HIGH = 2'h1,
        LCDCL_LEVEL_MID_LOW = 2'h2,
        LCDCL_LEVEL_BOTTOM = 2'h3
    } lcdcl_level_t;

    // Loader phase, one-hot
    typedef enum logic [2:0] {
        LCDCL_PH_LOAD = 3'h1,
        LCDCL_PH_FULL = 3'h2,
        LCDCL_PH_COPY = 3'h4
    } lcdcl_phase_t;

    // Whole state of the loader
    typedef struct packed {
        lcdcl_phase_t phase;
        logic sclk_prev;
        logic latch_prev;
        logic [`LCDCL_SLOT_W-1:0] count;
        logic [`LCDCL_COLS-1:0] stage1;
        logic [`LCDCL_COLS-1:0] stage2;
        logic [`LCDCL_COLS*`LCDCL_LEVEL_W-1:0] columns;
    } lcdcl_state_t;

endpackage

/* File: tb_top.sv */
// Self-checking bench for the column driver loader as first driver of a cascade.
// Assumes the controller model file and the design files are compiled before it.
`timescale 1ns/100ps
`include "lcdcl_defs.svh"
module tb_top;
    logic ref_clk_in;
    logic rst_n_in;
    logic shift_clock;
    logic [`LCDCL_NIB_W-1:0] nibble;
    logic latch_pulse;
    logic direction_select;
    logic frame_polarity;
    logic en_a_drv;
    logic en_b_drv;
    logic chain_a_pin;
    logic chain_a_out;
    logic chain_a_oe;
    logic chain_b_pin;
    logic chain_b_out;
    logic chain_b_oe;
    logic load_ready;
    logic [`LCDCL_COLS*`LCDCL_LEVEL_W-1:0] columns;
    int mismatches;
    int compares;

    // Pin level: the loader wins while it drives, else the neighbour drive
    assign chain_a_pin = chain_a_oe ? chain_a_out : en_a_drv;
    assign chain_b_pin = chain_b_oe ? chain_b_out : en_b_drv;

    lcdcl_ctrl_model i_lcdcl_ctrl_model (
        .ref_clk_in(ref_clk_in),
        .shift_clock_out(shift_clock),
        .nibble_out(nibble),
        .latch_pulse_out(latch_pulse)
    );

    lcdcl_loader i_lcdcl_loader (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .shift_clock_in(shift_clock),
        .nibble_inputs_in(nibble),
        .latch_pulse_in(latch_pulse),
        .direction_select_in(direction_select),
        .frame_polarity_in(frame_polarity),
        .chain_enable_a_in(chain_a_pin),
        .chain_enable_a_out(chain_a_out),
        .chain_enable_a_oe_out(chain_a_oe),
        .chain_enable_b_in(chain_b_pin),
        .chain_enable_b_out(chain_b_out),
        .chain_enable_b_oe_out(chain_b_oe),
        .load_ready_out(load_ready),
        .column_outputs_out(columns)
    );

    // 100 MHz reference clock
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    task automatic stop_test();
        if (mismatches == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    function automatic logic [1:0] exp_level(input logic bit_v, input logic pol);
        if (bit_v) begin
            return pol ? lcdcl_pkg::LCDCL_LEVEL_TOP : lcdcl_pkg::LCDCL_LEVEL_BOTTOM;
        end
        return pol ? lcdcl_pkg::LCDCL_LEVEL_MID_HIGH : lcdcl_pkg::LCDCL_LEVEL_MID_LOW;
    endfunction

    // Nibble k of a line; varied with k, repeating after 16 nibbles, so slots k and k+16 carry the same data
    function automatic logic [3:0] nib_of(input int k, input logic [3:0] base);
        return 4'(k) ^ base;
    endfunction

    // Expected line image: first bit to column 79 (dir low) or column 0 (dir high)
    function automatic logic [79:0] line_bits(input logic dir, input logic [3:0] base);
        logic [79:0] b;
        logic [3:0] n;
        b = '0;
        for (int k = 0; k < 20; k++) begin
            n = nib_of(k, base);
            for (int j = 0; j < 4; j++) begin
                if (dir) begin
                    b[4*k+j] = n[j];
                end else begin
                    b[79-4*k-j] = n[j];
                end
            end
        end
        return b;
    endfunction

    task automatic check_cols(input logic [79:0] bits, input logic pol);
        for (int c = 0; c < 80; c++) begin
            check($sformatf("column %0d", c), 8'(exp_level(bits[c], pol)), 8'(columns[2*c +: 2]));
        end
    endtask

    task automatic send_nibbles(input int n, input logic [3:0] base);
        for (int k = 0; k < n; k++) begin
            i_lcdcl_ctrl_model.send_nibble(nib_of(k, base));
        end
    endtask

    // Reset state: all columns from zero data, enables low
    task automatic test_reset();
        check("enable a", 8'h00, 8'(chain_a_out));
        check("enable b", 8'h00, 8'(chain_b_out));
        check("oe a", 8'h01, 8'(chain_a_oe));
        check("oe b", 8'h00, 8'(chain_b_oe));
        check("load ready", 8'h01, 8'(load_ready));
        check_cols(80'h0, 1'b0);
    endtask

    // Full line, with the enable raised on the 20th nibble only and an extra nibble dropped
    task automatic test_line(input logic dir, input logic [3:0] base, input logic pol);
        @(posedge ref_clk_in);
        direction_select <= dir;
        frame_polarity <= pol;
        repeat (3) @(posedge ref_clk_in);
        check("oe a", 8'(!dir), 8'(chain_a_oe));
        check("oe b", 8'(dir), 8'(chain_b_oe));
        send_nibbles(19, base);
        check("enable early", 8'h00, 8'(dir ? chain_b_out : chain_a_out));
        i_lcdcl_ctrl_model.send_nibble(nib_of(19, base));
        check("enable a full", 8'(!dir), 8'(chain_a_out));
        check("enable b full", 8'(dir), 8'(chain_b_out));
        i_lcdcl_ctrl_model.send_nibble(~base);
        i_lcdcl_ctrl_model.pulse_latch();
        check("enable a latched", 8'h00, 8'(chain_a_out));
        check("enable b latched", 8'h00, 8'(chain_b_out));
        check_cols(line_bits(dir, base), pol);
    endtask

    // Enable input low: nothing captured, old line comes back after the latch
    task automatic test_disabled(input logic [79:0] old_bits);
        @(posedge ref_clk_in);
        direction_select <= 1'b0;
        en_b_drv <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        send_nibbles(20, 4'h3);
        check("enable while off", 8'h00, 8'(chain_a_out));
        i_lcdcl_ctrl_model.pulse_latch();
        check_cols(old_bits, frame_polarity);
        @(posedge ref_clk_in);
        frame_polarity <= ~frame_polarity;
        repeat (4) @(posedge ref_clk_in);
        check_cols(old_bits, frame_polarity);
        en_b_drv <= 1'b1;
    endtask

    // Main sequence; first driver of the cascade, so its enable input is held high except during test_disabled
    initial begin
        mismatches = 0;
        compares = 0;
        rst_n_in = 1'b0;
        direction_select = 1'b0;
        frame_polarity = 1'b0;
        en_a_drv = 1'b1;
        en_b_drv = 1'b1;
        repeat (8) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        test_reset();
        test_line(1'b0, 4'h5, 1'b0);
        test_line(1'b1, 4'hA, 1'b1);
        test_disabled(line_bits(1'b1, 4'hA));
        test_line(1'b0, 4'hC, 1'b1);
        stop_test();
    end

    // Watchdog: the whole run needs about 1600 cycles
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        mismatches++;
        stop_test();
    end
endmodule
